// ==== hdl/dtc_defines.svh ====
// Constants of the dual timer/counter: field positions, reset values, timing.
// Assumes inclusion by bare name from the package; the design modules use its macros without including it.
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// ==========================================================
// Timing
// ==========================================================
`define DTC_PER_CLK_PER_CYCLE 3'h6
`define DTC_PRESCALE_BITS 5

// ==========================================================
// Mode register fields (timer 0 low nibble, timer 1 high nibble)
// ==========================================================
`define DTC_MODE_T0_LSB 0
`define DTC_MODE_T1_LSB 4
`define DTC_MODE_SEL_LO 0
`define DTC_MODE_SEL_HI 1
`define DTC_MODE_SRC 2
`define DTC_MODE_GATE 3

// ==========================================================
// Control register fields
// ==========================================================
`define DTC_CTL_RUN0 4
`define DTC_CTL_FLAG0 5
`define DTC_CTL_RUN1 6
`define DTC_CTL_FLAG1 7

// ==========================================================
// Reset values
// ==========================================================
`define DTC_RST_BYTE 8'h00
`define DTC_RST_MODE 8'h00

`endif

// ==== hdl/dtc_pkg.sv ====
// Types shared by the dual timer/counter design files.
// Assumes dtc_defines.svh is on the include path.
package dtc_pkg;
`include "dtc_defines.svh"

    // ==========================================================
    // Operating modes
    // ==========================================================
    typedef enum logic [1:0] {
        DTC_MODE_PRESCALE = 2'h0,
        DTC_MODE_FULL16 = 2'h1,
        DTC_MODE_RELOAD8 = 2'h2,
        DTC_MODE_SPLIT = 2'h3
    } dtc_mode_type;

    // Per-timer configuration taken from the mode register nibble
    typedef struct packed {
        logic gate_enable;
        logic source_sel;
        dtc_mode_type mode;
    } dtc_cfg_type;

    // Count pair of one timer
    typedef struct packed {
        logic [7:0] count_high_byte;
        logic [7:0] count_low_byte;
    } dtc_count_type;
endpackage

// ==== hdl/dtc_count_unit.sv ====
// One timer's count bytes with preset write and per-mode advance.
// Assumes the caller supplies a one-cycle step pulse for each byte.
`timescale 1ns/1ps

module dtc_count_unit
    import dtc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // Configuration and steps
    input wire dtc_mode_type mode_in,
    input wire logic step_low_in,
    input wire logic step_high_in,
    // Preset writes
    input wire logic wr_low_in,
    input wire logic wr_high_in,
    input wire logic [7:0] wr_data_in,
    // Count and overflow
    output dtc_count_type count_out,
    output logic ovf_low_out,
    output logic ovf_high_out
);

    // ==========================================================
    // Overflow detection
    // ==========================================================
    logic low_full;
    logic high_full;
    logic [7:0] next_low;
    logic [7:0] next_high;
    logic carry;

    // Prescale mode only uses the five low bits of the low byte
    assign low_full = (mode_in == DTC_MODE_PRESCALE)
        ? (count_out.count_low_byte[4:0] == 5'h1f)
        : (count_out.count_low_byte == 8'hff);
    assign high_full = (count_out.count_high_byte == 8'hff);

    // Cascade carry from low byte into high byte
    always_comb begin
        next_low = count_out.count_low_byte;
        next_high = count_out.count_high_byte;
        carry = 1'b0;
        if (step_low_in) begin
            next_low = count_out.count_low_byte + 8'h01;
            carry = low_full;
            if (mode_in == DTC_MODE_PRESCALE && low_full) begin
                next_low = {count_out.count_low_byte[7:5], 5'h00};
            end
            if (mode_in == DTC_MODE_RELOAD8 && low_full) begin
                next_low = count_out.count_high_byte;
            end
        end
        if ((carry && (mode_in == DTC_MODE_PRESCALE || mode_in == DTC_MODE_FULL16))
            || step_high_in) begin
            next_high = count_out.count_high_byte + 8'h01;
        end
    end

    // Count bytes; software preset overrides the advance
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            count_out <= {`DTC_RST_BYTE, `DTC_RST_BYTE};
        end else begin
            count_out.count_low_byte <= wr_low_in ? wr_data_in : next_low;
            count_out.count_high_byte <= wr_high_in ? wr_data_in : next_high;
        end
    end

    // Overflow pulses registered for the flag logic
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            ovf_low_out <= 1'b0;
            ovf_high_out <= 1'b0;
        end else begin
            ovf_low_out <= step_low_in && low_full && !wr_low_in;
            ovf_high_out <= (step_high_in || (carry && (mode_in == DTC_MODE_PRESCALE
                || mode_in == DTC_MODE_FULL16))) && high_full && !wr_high_in;
        end
    end
endmodule

// ==== hdl/dtc_top.sv ====
// Dual 16-bit timer/counter with external count and gate pins.
// Assumes a single 40 MHz clock; pins are asynchronous to it.
// Functional notes
// - Each timer cascades low byte into high byte; high overflow sets flag.
// - Run bit lets the selected input advance; setting it never clears counts.
// - Source bit picks divided clock (0) or count pin falling edges (1).
// - Timer operation advances once per six-clock peripheral cycle.
// - Count pin sampled once per cycle; high then low sample counts.
// - Gate clear: run bit alone enables; gate set adds gate pin.
// - Gated timer counts only while gate pin high and run set.
// - Rollover of all ones to zeros sets the overflow flag.
// - Mode bits: 00 prescaled, 01 sixteen-bit, 10 reload, 11 split/halt.
// - Mode 0 uses divide-by-32 prescaler in low-byte five bits.
// - Mode 2 low byte reloads from unchanged high byte on overflow.
// - Timer 0 mode 3 splits; high byte uses timer 1 run and flag.
// - Timer 1 in mode 3 halts and holds its count.
// - Timer 0 uses low mode nibble; timer 1 the high nibble.
// - Vectoring to a timer routine clears its overflow flag.
// - Interrupt request needs timer enable and global enable set.
//
// Design notes
// Presets win over the advance of the same cycle; the written byte loses that step, but a low-byte carry still steps the high byte.
// Mode 0 keeps the upper three low-byte bits as preset; software ignores them.
// Timer 1 keeps its own run bit while timer 0 is split; halt it by mode.
// Pin changes reach the count logic two clocks late through the synchroniser.
// The divider runs free from reset, so the first tick after start may come early.
// A counted pin level must stand a full six-clock cycle or it may be missed.
// An overflow in the cycle of a vector clear leaves the flag set.
// Status outputs trail the internal state by one clock.
`timescale 1ns/1ps

module dtc_top
    import dtc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // Control register image: run bits 4 and 6 written by software
    input wire logic ctl_wr_in,
    input wire logic [7:0] ctl_wdata_in,
    // Mode register write
    input wire logic mode_wr_in,
    input wire logic [7:0] mode_wdata_in,
    // Count byte preset writes: index 0 timer 0, index 1 timer 1
    input wire logic [1:0] wr_low_in,
    input wire logic [1:0] wr_high_in,
    input wire logic [7:0] wr_data_in,
    // Interrupt enables and vector acknowledge
    input wire logic [1:0] timer_irq_enable_in,
    input wire logic global_irq_enable_in,
    input wire logic [1:0] vector_ack_in,
    // External pins
    input wire logic [1:0] count_pin_in,
    input wire logic gate_pin_zero_in,
    input wire logic gate_pin_one_in,
    // Status
    output logic [7:0] timer_control_register_out,
    output logic [7:0] timer_mode_register_out,
    output dtc_count_type count_zero_out,
    output dtc_count_type count_one_out,
    output logic [1:0] irq_out
);

    // ==========================================================
    // Decoding helpers
    // ==========================================================
    function automatic dtc_cfg_type nibble_cfg(input logic [3:0] nib);
        dtc_cfg_type c;
        c.gate_enable = nib[`DTC_MODE_GATE];
        c.source_sel = nib[`DTC_MODE_SRC];
        c.mode = dtc_mode_type'(nib[1:0]);
        return c;
    endfunction

    // ==========================================================
    // Configuration and run bits
    // ==========================================================
    logic [7:0] mode_reg;
    logic run_control_bit [2];
    dtc_cfg_type cfg [2];

    // Mode register, timer 0 in the low nibble
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            mode_reg <= `DTC_RST_MODE;
        end else if (mode_wr_in) begin
            mode_reg <= mode_wdata_in;
        end
    end

    assign cfg[0] = nibble_cfg(mode_reg[`DTC_MODE_T0_LSB +: 4]);
    assign cfg[1] = nibble_cfg(mode_reg[`DTC_MODE_T1_LSB +: 4]);

    // Run bits; writing them never touches the count bytes
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            run_control_bit[0] <= 1'b0;
            run_control_bit[1] <= 1'b0;
        end else if (ctl_wr_in) begin
            run_control_bit[0] <= ctl_wdata_in[`DTC_CTL_RUN0];
            run_control_bit[1] <= ctl_wdata_in[`DTC_CTL_RUN1];
        end
    end

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;

    // Two flops on every asynchronous pin
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end else begin
            pin_meta <= {gate_pin_one_in, gate_pin_zero_in, count_pin_in};
            pin_sync <= pin_meta;
        end
    end

    // ==========================================================
    // Peripheral cycle divider
    // ==========================================================
    logic [2:0] div_cnt;
    logic per_tick;

    // One tick every six clocks
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            div_cnt <= 3'h0;
        end else if (div_cnt == `DTC_PER_CLK_PER_CYCLE - 3'h1) begin
            div_cnt <= 3'h0;
        end else begin
            div_cnt <= div_cnt + 3'h1;
        end
    end

    assign per_tick = (div_cnt == `DTC_PER_CLK_PER_CYCLE - 3'h1);

    // ==========================================================
    // Per-timer input selection
    // ==========================================================
    logic [1:0] enable;
    logic [1:0] step_low;
    logic [1:0] step_high;
    logic [1:0] ovf_low;
    logic [1:0] ovf_high;
    logic split_mode;
    logic t1_halt;
    dtc_count_type count [2];

    assign split_mode = (cfg[0].mode == DTC_MODE_SPLIT);
    assign t1_halt = (cfg[1].mode == DTC_MODE_SPLIT);

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_timer
            logic pin_sample;
            logic edge_seen;
            logic src_pulse;
            dtc_mode_type unit_mode;

            // Sample count pin once per peripheral cycle
            always_ff @(posedge core_clk_in) begin
                if (srst_in) begin
                    pin_sample <= 1'b0;
                    edge_seen <= 1'b0;
                end else begin
                    edge_seen <= 1'b0;
                    if (per_tick) begin
                        pin_sample <= pin_sync[gi];
                        edge_seen <= pin_sample && !pin_sync[gi];
                    end
                end
            end

            // Gating: run bit, optionally qualified by the gate pin
            assign enable[gi] = run_control_bit[gi]
                && (!cfg[gi].gate_enable || pin_sync[2 + gi]);

            // Count pulses for the low byte (or whole timer)
            assign src_pulse = cfg[gi].source_sel ? edge_seen : per_tick;

            // A halted timer 1 runs its unit as a plain counter that gets no steps
            assign unit_mode = (gi == 0 || !t1_halt) ? cfg[gi].mode : DTC_MODE_FULL16;
            if (gi == 0) begin : g_t0
                assign step_low[gi] = enable[gi] && src_pulse;
                assign step_high[gi] = split_mode && run_control_bit[1] && per_tick;
            end else begin : g_t1
                assign step_low[gi] = enable[gi] && src_pulse && !t1_halt;
                assign step_high[gi] = 1'b0;
            end

            dtc_count_unit u_count (
                .core_clk_in(core_clk_in),
                .srst_in(srst_in),
                .mode_in(unit_mode),
                .step_low_in(step_low[gi]),
                .step_high_in(step_high[gi]),
                .wr_low_in(wr_low_in[gi]),
                .wr_high_in(wr_high_in[gi]),
                .wr_data_in(wr_data_in),
                .count_out(count[gi]),
                .ovf_low_out(ovf_low[gi]),
                .ovf_high_out(ovf_high[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Overflow flags
    // ==========================================================
    logic [1:0] overflow_flag;
    logic [1:0] flag_set;

    // Flag sources: low-byte overflow in reload and in timer 0 split, whole count otherwise
    always_comb begin
        case (cfg[0].mode)
            DTC_MODE_RELOAD8: begin
                flag_set[0] = ovf_low[0];
            end
            DTC_MODE_SPLIT: begin
                flag_set[0] = ovf_low[0];
            end
            default: begin
                flag_set[0] = ovf_high[0];
            end
        endcase
        case (cfg[1].mode)
            DTC_MODE_RELOAD8: begin
                flag_set[1] = ovf_low[1];
            end
            default: begin
                flag_set[1] = ovf_high[1];
            end
        endcase
        // Timer 0's high byte takes timer 1's flag while split
        if (split_mode) begin
            flag_set[1] = ovf_high[0];
        end
    end

    // Set wins over the vector acknowledge clear
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            overflow_flag <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (flag_set[i]) begin
                    overflow_flag[i] <= 1'b1;
                end else if (vector_ack_in[i]) begin
                    overflow_flag[i] <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    logic [7:0] next_tcr;

    // Control image; bits not held by this block read as zero
    always_comb begin
        next_tcr = 8'h00;
        next_tcr[`DTC_CTL_RUN0] = run_control_bit[0];
        next_tcr[`DTC_CTL_FLAG0] = overflow_flag[0];
        next_tcr[`DTC_CTL_RUN1] = run_control_bit[1];
        next_tcr[`DTC_CTL_FLAG1] = overflow_flag[1];
    end

    // Register images
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            timer_control_register_out <= 8'h00;
            timer_mode_register_out <= 8'h00;
        end else begin
            timer_control_register_out <= next_tcr;
            timer_mode_register_out <= mode_reg;
        end
    end

    // Count images, one clock behind the count units
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            count_zero_out <= '0;
            count_one_out <= '0;
        end else begin
            count_zero_out <= count[0];
            count_one_out <= count[1];
        end
    end

    // Requests need the timer enable and the global enable
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            irq_out <= 2'h0;
        end else begin
            irq_out <= overflow_flag & timer_irq_enable_in
                & {2{global_irq_enable_in}};
        end
    end
endmodule

// ==== sim/dtc_top_assertions.sv ====
// Port checker for the dual timer/counter.
// Assumes the top module ports only; bound at the foot of this file.
`timescale 1ns/1ps

// ==========================================
// Checker
module dtc_top_assertions
    import dtc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // Requests
    input wire logic ctl_wr_in,
    input wire logic [7:0] ctl_wdata_in,
    input wire logic mode_wr_in,
    input wire logic [7:0] mode_wdata_in,
    input wire logic [1:0] wr_low_in,
    input wire logic global_irq_enable_in,
    input wire logic [1:0] vector_ack_in,
    input wire logic gate_pin_zero_in,
    // Status
    input wire logic [7:0] timer_control_register_out,
    input wire logic [7:0] timer_mode_register_out,
    input wire dtc_count_type count_zero_out,
    input wire logic [1:0] irq_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    logic [7:0] tcr, tmr, lo0, mode_img;
    logic [1:0] run_img;
    // Short views of the status ports
    assign tcr = timer_control_register_out;
    assign tmr = timer_mode_register_out;
    assign lo0 = count_zero_out.count_low_byte;
    // Last written run bits and mode byte
    always_ff @(posedge core_clk_in) begin
        if (ctl_wr_in) begin
            run_img <= {ctl_wdata_in[6], ctl_wdata_in[4]};
        end
        if (mode_wr_in) begin
            mode_img <= mode_wdata_in;
        end
    end
    // A write followed by two quiet cycles
    sequence s_ctl_done;
        ctl_wr_in ##1 !ctl_wr_in [*2];
    endsequence
    sequence s_mode_done;
        mode_wr_in ##1 !mode_wr_in [*2];
    endsequence
    sequence s_wrap0;
        count_zero_out == 16'hffff ##1 count_zero_out == 16'h0000;
    endsequence
    a_reset_zero: assert property (
        $past(srst_in) |-> tcr == 8'h00 && tmr == 8'h00 && count_zero_out == 16'h0000)
        else $error("outputs not clear after reset");
    a_run_load: assert property (
        s_ctl_done |-> {tcr[6], tcr[4]} == run_img) else $error("run bits not loaded");
    a_mode_load: assert property (
        s_mode_done |-> tmr == mode_img) else $error("mode byte not loaded");
    a_tick_space: assert property (
        $changed(lo0) && tmr[3:0] == 4'h1 && tcr[4] |=> $stable(lo0) [*5])
        else $error("timer steps closer than six clocks");
    a_flag_wrap: assert property (
        s_wrap0 |-> ##[0:2] tcr[5]) else $error("rollover did not set flag");
    a_flag_clear: assert property (
        vector_ack_in[0] && tmr[1:0] == 2'h1 |-> ##[1:3] !tcr[5])
        else $error("vector did not clear flag");
    a_irq_global: assert property (
        $past(!global_irq_enable_in) |-> irq_out == 2'h0) else $error("irq without global");
    a_stop_hold: assert property (
        !tcr[4] && !$past(tcr[4]) && !$past(wr_low_in[0], 2) |-> $stable(lo0))
        else $error("stopped timer moved");
    a_gate_block: assert property (
        (tmr[3] && !gate_pin_zero_in && !wr_low_in[0]) [*8] |-> $stable(lo0))
        else $error("gated timer counted with gate low");
endmodule

bind dtc_top dtc_top_assertions dtc_top_assertions_inst (.core_clk_in, .srst_in,
    .ctl_wr_in, .ctl_wdata_in, .mode_wr_in, .mode_wdata_in, .wr_low_in,
    .global_irq_enable_in, .vector_ack_in, .gate_pin_zero_in, .timer_control_register_out,
    .timer_mode_register_out, .count_zero_out, .irq_out);

// ==== sim/dtc_pin_model.sv ====
// Model of the outside source on the count and gate pins.
// Assumes the bench calls its tasks; pins change at falling edges.
`timescale 1ns/1ps

// ==========================================
// Pin source
module dtc_pin_model (
    // Clock
    input wire logic core_clk_in,
    // Pins toward the timer
    output logic [1:0] count_pin_out,
    output logic [1:0] gate_pin_out
);
    // Count pins idle high, gates closed
    initial begin
        count_pin_out = 2'h3;
        gate_pin_out = 2'h0;
    end
    // Falling edges; each level held at least one six-clock cycle
    task automatic pulse(input int idx, input int n, input int hold);
        repeat (n) begin
            repeat (hold) @(negedge core_clk_in);
            count_pin_out[idx] = 1'b0;
            repeat (hold) @(negedge core_clk_in);
            count_pin_out[idx] = 1'b1;
        end
    endtask
    // Gate pin level
    task automatic gate(input int idx, input logic v);
        @(negedge core_clk_in);
        gate_pin_out[idx] = v;
    endtask
endmodule

// ==== sim/test_dual_timer_counter.sv ====
// Self-checking bench for the dual timer/counter.
// Assumes dtc_top, the pin model and the bound checker.
`timescale 1ns/1ps

// ==========================================
// Bench
module test_dual_timer_counter;
    import dtc_pkg::*;
    logic core_clk_in = 1'b0, srst_in = 1'b1, ctl_wr_in = 1'b0, mode_wr_in = 1'b0;
    logic global_irq_enable_in = 1'b0;
    logic [7:0] ctl_wdata_in = 8'h00, mode_wdata_in = 8'h00, wr_data_in = 8'h00;
    logic [1:0] wr_low_in = 2'h0, wr_high_in = 2'h0, vector_ack_in = 2'h0;
    logic [1:0] timer_irq_enable_in = 2'h0, pins, gates, irq_out;
    logic [7:0] tcr, tmr;
    dtc_count_type count_zero_out, count_one_out;
    int fail_count = 0, checked = 0, n;
    dtc_top dtc_top_inst (.core_clk_in, .srst_in, .ctl_wr_in, .ctl_wdata_in, .mode_wr_in,
        .mode_wdata_in, .wr_low_in, .wr_high_in, .wr_data_in, .timer_irq_enable_in,
        .global_irq_enable_in, .vector_ack_in, .count_pin_in(pins),
        .gate_pin_zero_in(gates[0]), .gate_pin_one_in(gates[1]),
        .timer_control_register_out(tcr), .timer_mode_register_out(tmr),
        .count_zero_out, .count_one_out, .irq_out);
    dtc_pin_model dtc_pin_model_inst (.core_clk_in, .count_pin_out(pins),
        .gate_pin_out(gates));
    // 40 MHz clock
    always #12.5 core_clk_in = ~core_clk_in;
    // Verdict and end of run
    task automatic results;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] cnt(input int i);
        return i ? count_one_out : count_zero_out;
    endfunction
    // Bounded wait for a count value, cycles returned in n
    task automatic wait_cnt(input int i, input logic [15:0] exp, input int max);
        n = 0;
        do begin
            @(negedge core_clk_in);
            n++;
        end while (cnt(i) !== exp && n < max);
        if (cnt(i) !== exp) begin
            fail_count++;
            $display("mismatch at %0t: count %h never reached", $time, exp);
            results();
        end
    endtask
    // Control (sel 0) or mode (sel 1) write, then settle
    task automatic wr_reg(input bit sel, input logic [7:0] d);
        @(negedge core_clk_in);
        {mode_wr_in, ctl_wr_in} = sel ? 2'h2 : 2'h1;
        {mode_wdata_in, ctl_wdata_in} = {d, d};
        @(negedge core_clk_in);
        {mode_wr_in, ctl_wr_in} = 2'h0;
        repeat (8) @(negedge core_clk_in);
    endtask
    task automatic wr_byte(input int i, input bit hi, input logic [7:0] d);
        @(negedge core_clk_in);
        wr_data_in = d;
        {wr_high_in, wr_low_in} = hi ? {2'h1 << i, 2'h0} : {2'h0, 2'h1 << i};
        @(negedge core_clk_in);
        {wr_high_in, wr_low_in} = 4'h0;
    endtask
    task automatic preset(input int i, input logic [15:0] v);
        wr_byte(i, 1'b1, v[15:8]);
        wr_byte(i, 1'b0, v[7:0]);
        repeat (3) @(negedge core_clk_in);
    endtask
    task automatic ack(input logic [1:0] m);
        @(negedge core_clk_in);
        vector_ack_in = m;
        @(negedge core_clk_in);
        vector_ack_in = 2'h0;
        repeat (4) @(negedge core_clk_in);
    endtask
    // Main sequence
    initial begin
        repeat (2) @(negedge core_clk_in);
        srst_in = 1'b0;
        @(negedge core_clk_in);
        check({tcr, tmr}, 16'h0000);
        check(count_zero_out | count_one_out, 16'h0000);
        // Sixteen-bit timer, rollover, flag and interrupt
        wr_reg(1, 8'h11);
        preset(0, 16'hfffd);
        check(count_zero_out, 16'hfffd);
        timer_irq_enable_in = 2'h3;
        wr_reg(0, 8'h10);
        wait_cnt(0, 16'hffff, 20);
        wait_cnt(0, 16'h0000, 20);
        check(n[15:0], 16'h0006);
        repeat (3) @(negedge core_clk_in);
        check({8'h00, tcr & 8'h20}, 16'h0020);
        check({14'h0, irq_out}, 16'h0000);
        global_irq_enable_in = 1'b1;
        repeat (3) @(negedge core_clk_in);
        check({14'h0, irq_out}, 16'h0001);
        ack(2'h1);
        check({6'h0, irq_out, tcr & 8'h20}, 16'h0000);
        wr_reg(0, 8'h00);
        $display("test sixteen-bit done");
        // Auto-reload, high byte rewritten while running
        wr_reg(1, 8'h12);
        preset(0, 16'h80fe);
        wr_reg(0, 8'h10);
        wait_cnt(0, 16'h8080, 30);
        // Flag image trails the count image by one clock
        repeat (2) @(negedge core_clk_in);
        check({8'h00, tcr & 8'h20}, 16'h0020);
        wr_byte(0, 1'b1, 8'h40);
        wait_cnt(0, 16'h4040, 900);
        wr_reg(0, 8'h00);
        $display("test reload done");
        // Prescaled mode: five-bit prescaler feeds the high byte
        wr_reg(1, 8'h10);
        preset(0, 16'h00fe);
        wr_reg(0, 8'h10);
        wait_cnt(0, 16'h01e0, 30);
        wr_reg(0, 8'h00);
        $display("test prescaler done");
        // Gated event counting on each timer
        for (int i = 0; i < 2; i++) begin
            wr_reg(1, i ? 8'hd0 : 8'h0d);
            preset(i, 16'h0000);
            wr_reg(0, 8'h10 << (2 * i));
            dtc_pin_model_inst.pulse(i, 3, 6 + 5 * i);
            repeat (12) @(negedge core_clk_in);
            check(cnt(i), 16'h0000);
            dtc_pin_model_inst.gate(i, 1'b1);
            dtc_pin_model_inst.pulse(i, 3, 6 + 5 * i);
            repeat (12) @(negedge core_clk_in);
            check(cnt(i), 16'h0003);
            dtc_pin_model_inst.gate(i, 1'b0);
            wr_reg(0, 8'h00);
        end
        $display("test counter done");
        // Split timer 0 under run1, timer 1 halted
        ack(2'h3);
        wr_reg(1, 8'h33);
        preset(0, 16'hfe00);
        preset(1, 16'h1234);
        wr_reg(0, 8'h40);
        wait_cnt(0, 16'h0000, 30);
        repeat (3) @(negedge core_clk_in);
        check({6'h0, irq_out, tcr & 8'ha0}, 16'h0280);
        check(count_one_out, 16'h1234);
        wr_reg(0, 8'h00);
        $display("test split done");
        results();
    end
endmodule
